// file: rtl/bstc_tap.v
/*
 boundary scan test access port of the memory device: controller,
 instruction register, identity, bypass and boundary registers.
 assumes tck, tms, tdi arrive asynchronously and tck is much slower
 than mclk_i; pins stand for the memory i/o ring sampled and driven.
*/
//
// Operation
// - tms sampled each rising test clock
// - tdi captured on rising test clock
// - tdo updated on falling test clock
// - sixteen state test access controller
// - state changes only at rising edges
// - reset puts controller in test-logic-reset
// - five high tms samples force reset
// - tdi used only in shift states
// - tdo driven only in shift states
// - instruction selects data register in path
// - only extest takes pins, sample-z does not
// - instruction preset to identity code
// - new instruction active at update-ir
// - sample-z floats outputs, disables termination
// - bypass loads zero, shifts one bit
`timescale 1ns/1ns
`include "bstc_map.vh"
module bstc_tap #(
	parameter [`BSTC_ID_W-1:0] ID_VAL = `BSTC_ID_VAL,
	parameter BSR_W = `BSTC_BSR_W
) (
	input wire mclk_i,
	input wire sys_rst_i,
	input wire tck_i,
	input wire tms_i,
	input wire tdi_i,
	output reg tdo_o,
	output wire tdo_oe_o,
	input wire [BSR_W-1:0] pin_in_i,
	input wire [BSR_W-1:0] core_out_i,
	output wire [BSR_W-1:0] pin_out_o,
	output wire pin_take_o,
	output wire q_hiz_o,
	output wire odt_off_o
);
	// ------------------------------------------------------------
	// synchronise and find test clock edges
	// ------------------------------------------------------------
	wire [2:0] s_w;
	reg tck_d_reg;
	bstc_sync #(.W(3)) u_sync (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({tck_i, tms_i, tdi_i}),
		.sync_o(s_w)
	);
	// ring pins move with the memory clocks; capture is a snapshot,
	// so one pin may land an mclk later than its neighbour
	wire [BSR_W-1:0] pin_s;
	bstc_sync #(.W(BSR_W)) u_pin_sync (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(pin_in_i),
		.sync_o(pin_s)
	);
	wire tck_s = s_w[2];
	wire tms_s = s_w[1];
	wire tdi_s = s_w[0];
	wire rise = tck_s & ~tck_d_reg;
	wire fall = ~tck_s & tck_d_reg;
	always @(posedge mclk_i) begin
		if (sys_rst_i)
			tck_d_reg <= 1'b0;
		else
			tck_d_reg <= tck_s;
	end

	// ------------------------------------------------------------
	// controller
	// ------------------------------------------------------------
	reg [`BSTC_ST_W-1:0] st_reg;
	reg [`BSTC_ST_W-1:0] st_next;
	always @* begin
		case (st_reg)
		`BSTC_TLR: st_next = tms_s ? `BSTC_TLR : `BSTC_RTI;
		`BSTC_RTI: st_next = tms_s ? `BSTC_SDS : `BSTC_RTI;
		`BSTC_SDS: st_next = tms_s ? `BSTC_SIS : `BSTC_CDR;
		`BSTC_CDR: st_next = tms_s ? `BSTC_E1D : `BSTC_SDR;
		`BSTC_SDR: st_next = tms_s ? `BSTC_E1D : `BSTC_SDR;
		`BSTC_E1D: st_next = tms_s ? `BSTC_UDR : `BSTC_PDR;
		`BSTC_PDR: st_next = tms_s ? `BSTC_E2D : `BSTC_PDR;
		`BSTC_E2D: st_next = tms_s ? `BSTC_UDR : `BSTC_SDR;
		`BSTC_UDR: st_next = tms_s ? `BSTC_SDS : `BSTC_RTI;
		`BSTC_SIS: st_next = tms_s ? `BSTC_TLR : `BSTC_CIR;
		`BSTC_CIR: st_next = tms_s ? `BSTC_E1I : `BSTC_SIR;
		`BSTC_SIR: st_next = tms_s ? `BSTC_E1I : `BSTC_SIR;
		`BSTC_E1I: st_next = tms_s ? `BSTC_UIR : `BSTC_PIR;
		`BSTC_PIR: st_next = tms_s ? `BSTC_E2I : `BSTC_PIR;
		`BSTC_E2I: st_next = tms_s ? `BSTC_UIR : `BSTC_SIR;
		`BSTC_UIR: st_next = tms_s ? `BSTC_SDS : `BSTC_RTI;
		default: st_next = `BSTC_TLR;
		endcase
	end
	always @(posedge mclk_i) begin
		if (sys_rst_i)
			st_reg <= `BSTC_TLR;
		else if (rise)
			st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [`BSTC_IR_W-1:0] ir_sh_reg;
	reg [`BSTC_IR_W-1:0] ir_reg;
	reg [`BSTC_ID_W-1:0] id_sh_reg;
	reg byp_reg;
	wire [BSR_W-1:0] bsr_sh_w;
	wire [BSR_W-1:0] bsr_up_w;
	wire sh_ir = (st_reg == `BSTC_SIR);
	wire sh_dr = (st_reg == `BSTC_SDR);

	// ------------------------------------------------------------
	// instruction decode
	// ------------------------------------------------------------
	wire sel_bsr = (ir_reg == `BSTC_INS_EXTEST) |
		(ir_reg == `BSTC_INS_SAMPZ) | (ir_reg == `BSTC_INS_SAMPLE);
	wire sel_id = (ir_reg == `BSTC_INS_IDCODE);
	// private codes fall back to bypass so the chain stays defined
	wire sel_byp = ~sel_bsr & ~sel_id;
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ir_sh_reg <= `BSTC_IR_CAPT;
			ir_reg <= `BSTC_INS_IDCODE;
			id_sh_reg <= `BSTC_ID_ZERO;
			byp_reg <= 1'b0;
		end else if (rise) begin
			case (st_reg)
			`BSTC_CIR: ir_sh_reg <= `BSTC_IR_CAPT;
			`BSTC_SIR:
				ir_sh_reg <= {tdi_s, ir_sh_reg[`BSTC_IR_W-1:1]};
			`BSTC_UIR: ir_reg <= ir_sh_reg;
			`BSTC_CDR: begin
				if (sel_id)
					id_sh_reg <= ID_VAL;
				if (sel_byp)
					byp_reg <= 1'b0;
			end
			`BSTC_SDR: begin
				if (sel_id)
					id_sh_reg <= {tdi_s, id_sh_reg[`BSTC_ID_W-1:1]};
				if (sel_byp)
					byp_reg <= tdi_s;
			end
			default: begin
			end
			endcase
			// entering reset drops the instruction now, not a tck later
			if (st_next == `BSTC_TLR) begin
				ir_reg <= `BSTC_INS_IDCODE;
				ir_sh_reg <= `BSTC_IR_CAPT;
			end
		end
	end

	// ------------------------------------------------------------
	// boundary cells, one per ring pin
	// ------------------------------------------------------------
	// update cells hold still while the chain shifts
	wire bsr_cap = rise & (st_reg == `BSTC_CDR) & sel_bsr;
	wire bsr_shift = rise & sh_dr & sel_bsr;
	wire bsr_upd = rise & (st_reg == `BSTC_UDR) & sel_bsr;
	wire [BSR_W:0] bsr_chain = {tdi_s, bsr_sh_w};
	genvar gi;
	generate
		for (gi = 0; gi < BSR_W; gi = gi + 1) begin : g_cell
			reg cap_reg;
			reg upd_reg;
			always @(posedge mclk_i) begin
				if (sys_rst_i) begin
					cap_reg <= 1'b0;
					upd_reg <= 1'b0;
				end else begin
					if (bsr_cap)
						cap_reg <= pin_s[gi];
					else if (bsr_shift)
						cap_reg <= bsr_chain[gi + 1];
					if (bsr_upd)
						upd_reg <= cap_reg;
				end
			end
			assign bsr_sh_w[gi] = cap_reg;
			assign bsr_up_w[gi] = upd_reg;
		end
	endgenerate

	// ------------------------------------------------------------
	// serial output on falling edge
	// ------------------------------------------------------------
	reg oe_reg;
	reg tdo_next;
	// unknown codes end on the bypass bit
	always @* begin
		tdo_next = byp_reg;
		if (sh_ir)
			tdo_next = ir_sh_reg[0];
		else if (sel_id)
			tdo_next = id_sh_reg[0];
		else if (sel_bsr)
			tdo_next = bsr_sh_w[0];
	end
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			tdo_o <= 1'b0;
			oe_reg <= 1'b0;
		end else if (fall) begin
			tdo_o <= tdo_next;
			oe_reg <= sh_ir | sh_dr;
		end
	end
	assign tdo_oe_o = oe_reg;

	// ------------------------------------------------------------
	// pin takeover by extest; sample-z floats outputs, all else leaves memory untouched
	// ------------------------------------------------------------
	wire ext = (ir_reg == `BSTC_INS_EXTEST);
	assign pin_take_o = ext;
	assign pin_out_o = ext ? bsr_up_w : core_out_i;
	assign q_hiz_o = (ir_reg == `BSTC_INS_SAMPZ);
	assign odt_off_o = ext | q_hiz_o;
endmodule

// file: common/bstc_map.vh
/*
 constants for the boundary scan test access port: controller states,
 instruction codes, register lengths and identity value.
 assumes inclusion by bare name from the rtl files.
*/
`ifndef BSTC_MAP_VH
`define BSTC_MAP_VH

// ----------------------------------------------------------------
// controller states, one-hot
// ----------------------------------------------------------------
`define BSTC_ST_W 16
`define BSTC_TLR 16'h0001
`define BSTC_RTI 16'h0002
`define BSTC_SDS 16'h0004
`define BSTC_CDR 16'h0008
`define BSTC_SDR 16'h0010
`define BSTC_E1D 16'h0020
`define BSTC_PDR 16'h0040
`define BSTC_E2D 16'h0080
`define BSTC_UDR 16'h0100
`define BSTC_SIS 16'h0200
`define BSTC_CIR 16'h0400
`define BSTC_SIR 16'h0800
`define BSTC_E1I 16'h1000
`define BSTC_PIR 16'h2000
`define BSTC_E2I 16'h4000
`define BSTC_UIR 16'h8000

// ----------------------------------------------------------------
// instructions
// ----------------------------------------------------------------
`define BSTC_IR_W 3
`define BSTC_INS_EXTEST 3'h0
`define BSTC_INS_IDCODE 3'h1
`define BSTC_INS_SAMPZ 3'h2
`define BSTC_INS_SAMPLE 3'h4
`define BSTC_INS_BYPASS 3'h7
`define BSTC_IR_CAPT 3'h1

// ----------------------------------------------------------------
// data registers
// ----------------------------------------------------------------
`define BSTC_ID_W 32
// arbitrary identity value
`define BSTC_ID_VAL 32'h0000_0001
`define BSTC_BSR_W 8
`define BSTC_BSR_ZERO 8'h00
`define BSTC_ID_ZERO 32'h0000_0000

`endif

// file: rtl/bstc_sync.v
/*
 two flip-flop synchroniser, one bit per lane.
 assumes asynchronous inputs and a free running mclk_i.
*/
`timescale 1ns/1ns
module bstc_sync #(
	parameter W = 3
) (
	input wire mclk_i,
	input wire sys_rst_i,
	input wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;
	// ------------------------------------------------------------
	// first stage read only by second
	// ------------------------------------------------------------
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			meta_reg <= {W{1'b0}};
			sync_reg <= {W{1'b0}};
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end
	assign sync_o = sync_reg;
endmodule

// file: tb/bstc_tester.sv
/* tester model: drives test clock, mode select and data in.
 assumes free running mclk_i; tck stands still between steps. */
`timescale 1ns/1ns
module bstc_tester (
	input wire mclk_i,
	input wire tdo_i,
	input wire tdo_oe_i,
	output reg tck_o,
	output reg tms_o,
	output reg tdi_o
);
initial begin
	tck_o = 1'b0;
	tms_o = 1'b1;
	tdi_o = 1'b1;
end
// ----------------------------------------------------------------
// one tck period of 8 mclk, tdo read at the rise
// ----------------------------------------------------------------
task step(input m, input d, output q);
	begin
		@(posedge mclk_i);
		tck_o <= 1'b0;
		tms_o <= m;
		tdi_o <= d;
		repeat (4) @(posedge mclk_i);
		tck_o <= 1'b1;
		// undriven tdo is unknown, never a match
		#1 q = tdo_oe_i ? tdo_i : 1'bx;
		repeat (3) @(posedge mclk_i);
		// let this edge's updates settle before the caller looks
		#1;
	end
endtask
endmodule

// file: tb/bstc_tap_props.sv
/* port checker for the tap.
 assumes bind onto bstc_tap, tck much slower than mclk_i. */
`timescale 1ns/1ns
module bstc_tap_props #(parameter BSR_W = 8) (
	input wire mclk_i,
	input wire sys_rst_i,
	input wire tck_i,
	input wire tms_i,
	input wire tdo_o,
	input wire tdo_oe_o,
	input wire [BSR_W-1:0] core_out_i,
	input wire [BSR_W-1:0] pin_out_o,
	input wire pin_take_o,
	input wire q_hiz_o,
	input wire odt_off_o
);
// ----------------------------------------------------------------
// helper: raw rises seen with tms high, saturating
// ----------------------------------------------------------------
reg tck_prev_reg;
reg [2:0] ones_reg;
always @(posedge mclk_i) begin
	tck_prev_reg <= tck_i;
	if (sys_rst_i)
		ones_reg <= 3'h0;
	else if (tck_i && !tck_prev_reg)
		ones_reg <= !tms_i ? 3'h0 : (ones_reg == 3'h5) ? 3'h5 : ones_reg + 3'h1;
end
default clocking @(posedge mclk_i); endclocking
default disable iff (sys_rst_i);
chk_rst_quiet: assert property (disable iff (1'b0)
	sys_rst_i |=> !tdo_oe_o && !pin_take_o && !q_hiz_o)
	else $error("outputs active after reset");
chk_pins_follow: assert property (!pin_take_o |->
	pin_out_o == core_out_i) else $error("pins taken without extest");
chk_odt_covers: assert property ((pin_take_o || q_hiz_o) |->
	odt_off_o) else $error("termination left on");
chk_mode_excl: assert property (!(pin_take_o && q_hiz_o))
	else $error("two pin modes at once");
chk_tdo_fall: assert property ($changed({tdo_o, tdo_oe_o})
	|-> !tck_i && !$past(tck_i, 2)) else $error("tdo moved off a fall");
chk_ins_rise: assert property (
	$changed({pin_take_o, q_hiz_o}) |-> tck_i && $past(tck_i, 2))
	else $error("instruction moved off a rise");
chk_five_ones: assert property (ones_reg == 3'h5 |->
	##[0:4] (!pin_take_o && !q_hiz_o)) else $error("no reset after ones");
chk_idle_still: assert property ($stable(tck_i) [*5] |=>
	$stable({tdo_o, tdo_oe_o, pin_take_o, q_hiz_o}))
	else $error("change with test clock still");
endmodule
bind bstc_tap bstc_tap_props #(.BSR_W(BSR_W)) u_props (.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i), .tck_i(tck_i), .tms_i(tms_i), .tdo_o(tdo_o),
	.tdo_oe_o(tdo_oe_o), .core_out_i(core_out_i), .pin_out_o(pin_out_o),
	.pin_take_o(pin_take_o), .q_hiz_o(q_hiz_o), .odt_off_o(odt_off_o));

// file: tb/bstc_tap_tb.sv
/* self-checking bench for the tap.
 assumes the tester model steps tck at 320 ns. */
`timescale 1ns/1ns
`include "bstc_map.vh"
module bstc_tap_tb;
reg mclk_i = 1'b0;
reg sys_rst_i = 1'b1;
reg [7:0] pin_in_i = 8'h5a;
reg [7:0] core_out_i = 8'h3c;
wire tck, tms, tdi, tdo_o, tdo_oe_o, pin_take_o, q_hiz_o, odt_off_o;
wire [7:0] pin_out_o;
integer bad_count = 0;
integer samples_checked = 0;
reg [31:0] got;
always #20 mclk_i = ~mclk_i;
bstc_tap u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .tck_i(tck),
	.tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
	.pin_in_i(pin_in_i), .core_out_i(core_out_i), .pin_out_o(pin_out_o),
	.pin_take_o(pin_take_o), .q_hiz_o(q_hiz_o), .odt_off_o(odt_off_o));
bstc_tester u_host (.mclk_i(mclk_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o),
	.tck_o(tck), .tms_o(tms), .tdi_o(tdi));
// ----------------------------------------------------------------
// shared tasks
// ----------------------------------------------------------------
task check(input [63:0] what, input [31:0] seen, input [31:0] want);
	begin
		samples_checked = samples_checked + 1;
		if (seen !== want) begin
			bad_count = bad_count + 1;
			$display("unexpected %0s: expected %h seen %h", what, want, seen);
		end
	end
endtask
task go(input [7:0] seq, input integer n);
	integer i;
	reg q;
	for (i = 0; i < n; i = i + 1)
		u_host.step(seq[i], 1'b1, q);
endtask
// lsb first, tms high on the last bit leaves for exit
task shift(input [31:0] din, input integer n, output [31:0] dout);
	integer i;
	reg q;
	begin
		dout = 32'h0;
		for (i = 0; i < n; i = i + 1) begin
			u_host.step(i == n - 1, din[i], q);
			dout[i] = q;
		end
	end
endtask
task load_ir(input [2:0] ins);
	begin
		go(8'h03, 4);
		shift({29'h0, ins}, 3, got);
		check("ircap", got, {29'h0, `BSTC_IR_CAPT});
	end
endtask
task complete_run;
	begin
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
endtask
// ----------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------
task t_idcode;
	begin
		go(8'h02, 4);
		shift(32'h0, 32, got);
		check("idcode", got, `BSTC_ID_VAL);
		go(8'h01, 2);
		check("oe", tdo_oe_o, 32'h0);
	end
endtask
task t_bypass;
	begin
		load_ir(`BSTC_INS_BYPASS);
		go(8'h03, 4);
		shift(32'hd, 4, got);
		check("bypass", got, 32'ha);
		go(8'h01, 2);
	end
endtask
task t_sampz;
	begin
		load_ir(`BSTC_INS_SAMPZ);
		check("early", q_hiz_o, 32'h0);
		go(8'h05, 5);
		check("hiz", {q_hiz_o, odt_off_o, pin_take_o}, 32'h6);
		check("pins", pin_out_o, core_out_i);
		shift(32'h0, 8, got);
		check("zcap", got, pin_in_i);
		go(8'h01, 2);
		load_ir(`BSTC_INS_SAMPLE);
		go(8'h01, 2);
		check("sample", {q_hiz_o, odt_off_o, pin_take_o}, 32'h0);
	end
endtask
task t_extest;
	begin
		load_ir(`BSTC_INS_EXTEST);
		go(8'h05, 5);
		check("take", {pin_take_o, odt_off_o}, 32'h3);
		shift(32'hc3, 8, got);
		check("bsr", got, pin_in_i);
		go(8'h01, 2);
		check("pinout", pin_out_o, 32'hc3);
		go(8'h1f, 5);
		check("reset", {pin_take_o, odt_off_o}, 32'h0);
	end
endtask
initial begin
	repeat (10) @(posedge mclk_i);
	sys_rst_i <= 1'b0;
	repeat (4) @(posedge mclk_i);
	t_idcode;
	t_bypass;
	t_sampz;
	t_extest;
	complete_run;
end
initial begin
	#200000;
	bad_count = bad_count + 1;
	complete_run;
end
endmodule
